// [hw/scdt_pkg.sv]
`default_nettype none
package scdt_pkg;
  localparam int unsigned data_width = 14;
  localparam int unsigned latency_cycles = 8;
  localparam int unsigned lock_cycles = 100;
  localparam int unsigned fifo_depth = 8;
  localparam int unsigned lock_count_width = 7;
  localparam logic [6:0] lock_count_last = 7'h63;
  localparam logic [1:0] div_count_full = 2'h0;
  localparam logic [1:0] div_count_half = 2'h1;
  localparam logic [1:0] div_count_quarter = 2'h3;
  typedef enum logic [1:0] {
    scdt_mode_full = 2'h0,
    scdt_mode_half = 2'h1,
    scdt_mode_quarter = 2'h2,
    scdt_mode_illegal = 2'h3
  } scdt_mode_t;
  typedef enum {scdt_lock_wait, scdt_lock_done} scdt_lock_t;
endpackage : scdt_pkg
`default_nettype wire

// [hw/scdt_link_if.sv]
`default_nettype none
interface scdt_link_if;
  logic [scdt_pkg::data_width-1:0] data_a;
  logic [scdt_pkg::data_width-1:0] data_b;
  logic range_overflow_flag_a;
  logic range_overflow_flag_b;
  logic data_valid_strobe;
  logic half_rate_select;
  logic quarter_rate_select;
  logic clock_input_type_select;
  modport converter (
    output data_a, data_b, range_overflow_flag_a, range_overflow_flag_b,
    output data_valid_strobe,
    input half_rate_select, quarter_rate_select, clock_input_type_select
  );
  modport back_end (
    input data_a, data_b, range_overflow_flag_a, range_overflow_flag_b,
    input data_valid_strobe,
    output half_rate_select, quarter_rate_select, clock_input_type_select
  );
endinterface : scdt_link_if
`default_nettype wire

// [hw/scdt_fifo.sv]
`default_nettype none
module scdt_fifo #(
  parameter int unsigned width = 30,
  parameter int unsigned depth = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int unsigned aw = $clog2(depth);
  logic [width-1:0] mem [depth];
  logic [aw-1:0] wr_ptr;
  logic [aw-1:0] rd_ptr;
  logic [aw:0] count;
  logic push;
  logic pop;
  assign in_ready = count != (aw+1)'(depth);
  assign out_valid = count != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == aw'(depth - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == aw'(depth - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (aw+1)'(push) - (aw+1)'(pop);
    end
  end
endmodule : scdt_fifo
`default_nettype wire

// [hw/scdt_converter.sv]
// Overview of operation
// - two select pins form mode; both high illegal
// - both low: sample every clock
// - half-rate pin: sample every second clock
// - quarter-rate pin: sample every fourth clock
// - sample on falling positive clock edge
// - result appears eight clocks after sample
// - about 100 clocks to relock
// - timing independent of clock duty cycle
// - strobe synchronous with output words
// - back end may capture on clock
// - type pin selects differential or single-ended
// - data changes on the same edge that sets strobe
// - overflow flag follows data latency
`default_nettype none
module scdt_converter (
  input wire logic ref_clk,
  input wire logic rst,
  scdt_link_if.converter link,
  input wire logic [scdt_pkg::data_width-1:0] sample_a,
  input wire logic [scdt_pkg::data_width-1:0] sample_b,
  input wire logic over_range_a,
  input wire logic over_range_b,
  output logic locked,
  output logic differential_clock,
  output logic mode_illegal
);
  localparam int unsigned w = scdt_pkg::data_width;
  localparam int unsigned lat = scdt_pkg::latency_cycles;
  logic [1:0] sel_meta;
  logic [1:0] sel_sync;
  logic type_meta;
  logic type_sync;
  scdt_pkg::scdt_mode_t mode;
  scdt_pkg::scdt_mode_t prev_mode;
  logic [1:0] div_count;
  logic [1:0] div_last;
  logic sample_tick;
  logic [scdt_pkg::lock_count_width-1:0] lock_count;
  scdt_pkg::scdt_lock_t lock_state;
  logic [2*w+1:0] pipe_data [lat];
  logic [lat-1:0] pipe_valid;
  logic mode_change;
  logic sample_take;
  logic out_load;
  // pins come from outside: two flops before use
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      sel_meta <= 2'h0;
      sel_sync <= 2'h0;
    end
    else
    begin
      sel_meta <= {link.quarter_rate_select, link.half_rate_select};
      sel_sync <= sel_meta;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      type_meta <= 1'b0;
      type_sync <= 1'b0;
    end
    else
    begin
      type_meta <= link.clock_input_type_select;
      type_sync <= type_meta;
    end
  end
  assign mode = scdt_pkg::scdt_mode_t'(sel_sync);
  assign mode_illegal = mode == scdt_pkg::scdt_mode_illegal;
  assign differential_clock = type_sync;
  assign mode_change = mode != prev_mode;
  always_comb
  begin
    unique case (mode)
      scdt_pkg::scdt_mode_full: div_last = scdt_pkg::div_count_full;
      scdt_pkg::scdt_mode_half: div_last = scdt_pkg::div_count_half;
      scdt_pkg::scdt_mode_quarter:
        div_last = scdt_pkg::div_count_quarter;
      scdt_pkg::scdt_mode_illegal: div_last = scdt_pkg::div_count_full;
    endcase
  end
  // one tick per sampling instant; illegal code takes no samples
  assign sample_tick = !mode_change && !mode_illegal && div_count == 2'h0;
  // ticks before lock are dropped, not queued
  assign sample_take = sample_tick && locked;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prev_mode <= scdt_pkg::scdt_mode_full;
    end
    else
    begin
      prev_mode <= mode;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      div_count <= 2'h0;
    end
    else if (mode_change || div_count == div_last)
    begin
      div_count <= 2'h0;
    end
    else
    begin
      div_count <= div_count + 2'h1;
    end
  end
  // lock interval restarts on reset and on any mode change
  always_ff @(posedge ref_clk)
  begin
    if (rst || mode_change)
    begin
      lock_state <= scdt_pkg::scdt_lock_wait;
      lock_count <= '0;
    end
    else
    begin
      unique case (lock_state)
        scdt_pkg::scdt_lock_wait:
        begin
          if (lock_count == scdt_pkg::lock_count_last)
          begin
            lock_state <= scdt_pkg::scdt_lock_done;
          end
          else
          begin
            lock_count <= lock_count + 1'b1;
          end
        end
        scdt_pkg::scdt_lock_done: lock_count <= lock_count;
      endcase
    end
  end
  assign locked = lock_state == scdt_pkg::scdt_lock_done;
  // single-clock model: every stage is edge-based, duty cycle irrelevant
  // sampling edge is the ref_clk edge standing for the falling clock edge
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pipe_valid <= '0;
    end
    else
    begin
      pipe_valid <= {pipe_valid[lat-2:0], sample_take};
    end
  end
  always_ff @(posedge ref_clk)
  begin
    pipe_data[0] <= {over_range_b, over_range_a,
      sample_b, sample_a};
  end
  genvar gi;
  generate
    for (gi = 1; gi < lat; gi++)
    begin : g_pipe
      always_ff @(posedge ref_clk)
      begin
        pipe_data[gi] <= pipe_data[gi-1];
      end
    end
  endgenerate
  // words still in the pipe when lock drops are discarded
  assign out_load = pipe_valid[lat-1] && locked;
  // data and strobe load on one edge, so a high strobe marks valid data
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      link.data_a <= '0;
      link.data_b <= '0;
    end
    else if (out_load)
    begin
      link.data_a <= pipe_data[lat-1][w-1:0];
      link.data_b <= pipe_data[lat-1][2*w-1:w];
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      link.range_overflow_flag_a <= 1'b0;
      link.range_overflow_flag_b <= 1'b0;
    end
    else if (out_load)
    begin
      link.range_overflow_flag_a <= pipe_data[lat-1][2*w];
      link.range_overflow_flag_b <= pipe_data[lat-1][2*w+1];
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      link.data_valid_strobe <= 1'b0;
    end
    else
    begin
      link.data_valid_strobe <= out_load;
    end
  end
endmodule : scdt_converter
`default_nettype wire

// [hw/scdt_back_end.sv]
`default_nettype none
module scdt_back_end (
  input wire logic ref_clk,
  input wire logic rst,
  scdt_link_if.back_end link,
  input wire logic [1:0] mode_request,
  input wire logic differential_request,
  output logic capture_valid,
  input wire logic capture_ready,
  output logic [2*scdt_pkg::data_width+1:0] capture_data,
  output logic trusted,
  output logic overrun
);
  localparam int unsigned cw = 2 * scdt_pkg::data_width + 2;
  logic [1:0] mode_pins;
  logic [1:0] prev_pins;
  logic [scdt_pkg::lock_count_width-1:0] wait_count;
  logic take;
  logic fifo_ready;
  // never drive both select pins high
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      mode_pins <= 2'h0;
      link.clock_input_type_select <= 1'b0;
    end
    else
    begin
      if (mode_request != 2'h3)
      begin
        mode_pins <= mode_request;
      end
      link.clock_input_type_select <= differential_request;
    end
  end
  assign link.half_rate_select = mode_pins[0];
  assign link.quarter_rate_select = mode_pins[1];
  // trust words only after the relock interval
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      prev_pins <= 2'h0;
      wait_count <= '0;
      trusted <= 1'b0;
    end
    else
    begin
      prev_pins <= mode_pins;
      if (prev_pins != mode_pins)
      begin
        wait_count <= '0;
        trusted <= 1'b0;
      end
      else if (wait_count == scdt_pkg::lock_count_last)
      begin
        trusted <= 1'b1;
      end
      else
      begin
        wait_count <= wait_count + 1'b1;
      end
    end
  end
  // each strobe cycle carries a fresh word; full rate keeps it high
  // strobe comes from the same clock, so no sync is needed
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      overrun <= 1'b0;
    end
    else if (take && !fifo_ready)
    begin
      overrun <= 1'b1;
    end
  end
  assign take = link.data_valid_strobe && trusted;
  scdt_fifo #(
    .width(cw),
    .depth(scdt_pkg::fifo_depth)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(take),
    .in_ready(fifo_ready),
    .in_data({link.range_overflow_flag_b, link.range_overflow_flag_a,
      link.data_b, link.data_a}),
    .out_valid(capture_valid),
    .out_ready(capture_ready),
    .out_data(capture_data)
  );
endmodule : scdt_back_end
`default_nettype wire

// [sim/scdt_link_assertions.sv]
`default_nettype none
module scdt_link_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [scdt_pkg::data_width-1:0] data_a,
  input wire logic [scdt_pkg::data_width-1:0] data_b,
  input wire logic range_overflow_flag_a,
  input wire logic range_overflow_flag_b,
  input wire logic data_valid_strobe,
  input wire logic half_rate_select,
  input wire logic quarter_rate_select,
  input wire logic clock_input_type_select
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] pins;
  logic [1:0] pins_q;
  logic [4:0] since_chg;
  logic [6:0] since_rst;
  logic settled;
  assign pins = {quarter_rate_select, half_rate_select};
  // the counter clears one edge late, so a fresh pin move also unsettles
  assign settled = since_chg == 5'h1f && pins == pins_q;
  always_ff @(posedge ref_clk)
  begin
    pins_q <= rst ? 2'h0 : pins;
  end
  // cycles since the mode pins last moved
  always_ff @(posedge ref_clk)
  begin
    if (rst || pins != pins_q)
      since_chg <= 5'h00;
    else if (!settled)
      since_chg <= since_chg + 5'h01;
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      since_rst <= 7'h00;
    else if (since_rst != 7'h7f)
      since_rst <= since_rst + 7'h01;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_gap3;
    !data_valid_strobe [*3];
  endsequence
  sequence s_quiet;
    !data_valid_strobe [*8];
  endsequence
  property p_pins_legal;
    !(half_rate_select && quarter_rate_select);
  endproperty
  property p_full;
    data_valid_strobe && pins == 2'h0 && settled |=> data_valid_strobe;
  endproperty
  property p_half;
    data_valid_strobe && pins == 2'h1 && settled |=> !data_valid_strobe;
  endproperty
  property p_quarter;
    data_valid_strobe && pins == 2'h2 && settled |=> s_gap3;
  endproperty
  property p_data_hold;
    !data_valid_strobe |-> $stable(data_a) && $stable(data_b);
  endproperty
  property p_flag_hold;
    !data_valid_strobe |-> $stable({range_overflow_flag_a,
                                    range_overflow_flag_b});
  endproperty
  property p_relock;
    $changed(pins) |=> ##11 s_quiet;
  endproperty
  property p_first_lock;
    data_valid_strobe |-> since_rst > 7'h64;
  endproperty
  a_pins_legal: assert property (p_pins_legal)
    else $error("both divider pins high");
  a_full: assert property (p_full)
    else $error("full rate strobe gap");
  a_half: assert property (p_half)
    else $error("half rate strobe spacing");
  a_quarter: assert property (p_quarter)
    else $error("quarter rate strobe spacing");
  a_data_hold: assert property (p_data_hold)
    else $error("data moved without strobe");
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag moved without strobe");
  a_relock: assert property (p_relock)
    else $error("strobe during relock");
  a_first_lock: assert property (p_first_lock)
    else $error("strobe before lock");
endmodule : scdt_link_assertions
`default_nettype wire

// [sim/test_adc_sample_clock_divider_timing.sv]
`default_nettype none
module test_adc_sample_clock_divider_timing;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [13:0] sa = 14'h0000;
  logic ora = 1'b0;
  logic [1:0] mreq = 2'h0;
  logic dreq = 1'b0;
  logic cready = 1'b1;
  logic cvalid, locked, diffc, illeg, trusted, overrun;
  logic [29:0] cdata;
  int cyc = 0;
  int fail_count = 0;
  int n_compared = 0;
  scdt_link_if link ();
  scdt_converter scdt_converter_i (.ref_clk(ref_clk), .rst(rst),
    .link(link), .sample_a(sa), .sample_b(~sa), .over_range_a(ora),
    .over_range_b(ora), .locked(locked), .differential_clock(diffc),
    .mode_illegal(illeg));
  scdt_back_end scdt_back_end_i (.ref_clk(ref_clk), .rst(rst),
    .link(link), .mode_request(mreq), .differential_request(dreq),
    .capture_valid(cvalid), .capture_ready(cready), .capture_data(cdata),
    .trusted(trusted), .overrun(overrun));
  scdt_link_assertions scdt_link_assertions_i (.ref_clk(ref_clk),
    .rst(rst), .data_a(link.data_a), .data_b(link.data_b),
    .range_overflow_flag_a(link.range_overflow_flag_a),
    .range_overflow_flag_b(link.range_overflow_flag_b),
    .data_valid_strobe(link.data_valid_strobe),
    .half_rate_select(link.half_rate_select),
    .quarter_rate_select(link.quarter_rate_select),
    .clock_input_type_select(link.clock_input_type_select));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  // sample stand-ins carry the edge count, so latency is readable
  always @(negedge ref_clk)
  begin
    sa <= 14'(cyc);
    ora <= cyc[0];
  end
  task chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      $display("[ERR] %0t %s", $time, msg);
      fail_count++;
    end
  endtask : chk
  task wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_n
  task wrap_up();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task t_latency();
    int k;
    int lag;
    // stand-in sample lags the edge count by one
    lag = int'(scdt_pkg::latency_cycles) + 1;
    for (k = 0; k < 40 && link.data_valid_strobe !== 1'b1; k++)
      wait_n(1);
    for (k = 0; k < 4; k++)
    begin
      chk(link.data_a === 14'(cyc - lag), "latency");
      chk(link.data_b === ~link.data_a, "channel b");
      chk(link.range_overflow_flag_a === link.data_a[0], "flag");
      chk(link.range_overflow_flag_b === link.data_a[0], "flag b");
      wait_n(1);
    end
  endtask : t_latency
  task t_rate(input logic [1:0] m, input int want);
    int k;
    int n;
    mreq = m;
    wait_n(6);
    chk(locked === 1'b0 && trusted === 1'b0, "no relock");
    wait_n(125);
    n = 0;
    for (k = 0; k < 40; k++)
    begin
      n += int'(link.data_valid_strobe === 1'b1);
      wait_n(1);
    end
    chk(n == want, "rate");
  endtask : t_rate
  task t_clock_type();
    dreq = 1'b1;
    wait_n(4);
    chk(link.clock_input_type_select === 1'b1, "type pin");
    chk(diffc === 1'b1, "diff");
    dreq = 1'b0;
    wait_n(4);
    chk(diffc === 1'b0, "single");
  endtask : t_clock_type
  task t_buffer();
    logic [13:0] first;
    int k;
    cready = 1'b0;
    wait_n(20);
    chk(overrun === 1'b1 && cvalid === 1'b1, "no overrun");
    mreq = 2'h1;
    wait_n(16);
    cready = 1'b1;
    first = cdata[13:0];
    for (k = 0; k < scdt_pkg::fifo_depth; k++)
    begin
      chk(cdata[13:0] === first + 14'(k), "order");
      chk(cdata[28] === cdata[0] && cvalid === 1'b1, "pair");
      wait_n(1);
    end
    chk(cvalid === 1'b0, "not empty");
  endtask : t_buffer
  task t_illegal();
    mreq = 2'h3;
    wait_n(5);
    chk(link.quarter_rate_select === 1'b0, "pins");
    chk(link.half_rate_select === 1'b1 && illeg === 1'b0, "kept");
  endtask : t_illegal
  initial
  begin
    wait_n(10);
    rst = 1'b0;
    wait_n(115);
    chk(locked === 1'b1 && trusted === 1'b1, "lock");
    t_latency();
    t_clock_type();
    t_buffer();
    t_rate(2'h2, 10);
    t_rate(2'h0, 40);
    t_rate(2'h1, 20);
    t_illegal();
    wrap_up();
  end
  initial
  begin
    #50000;
    fail_count++;
    wrap_up();
  end
endmodule : test_adc_sample_clock_divider_timing
`default_nettype wire
